/* File: logic/lwic_ctrl.sv */
// Pipelined long-word instruction fetch, decode and bus steering.
// Assumes a dual-port store with combinational read on both ports and
// a 16-bit register/ALU slice, all on CLK_SYS; Wishbone classic slave.
//
// Notes on behaviour
// [RULE1] Fetch one 64-bit word per cycle; 50 bits basic, 14 spare.
// [RULE2] Each instruction word equals four consecutive 16-bit data words.
// [RULE3] Two 6-bit fields give the slice's two register addresses.
// [RULE4] Function field drives ten slice inputs; separate carry and status-load bits.
// [RULE5] Shift field gates slice shift-in and shift-out.
// [RULE6] Data-input select picks data bus, immediate, or program counter.
// [RULE7] First field is bus-read source, second is bus-write destination.
// [RULE8] Without bus read, slice output drives the data bus; here immediate drives it when data input selects immediate or counter.
// [RULE9] Memory-write stores bus data; address-load captures it; both allowed.
// [RULE10] Bus read disables slice outputs; chosen I/O register drives bus.
// [RULE11] Bus write stores bus data into I/O register chosen by second field.
// [RULE12] Jump field loads program counter from bus, immediate or register.
// [RULE13] Conditional jump: first field selects condition; load only when true.
// [RULE14] Fourteen spare bits come out directly as strobes.
// [RULE15] Memory load or store takes address load then the transfer.
// [RULE16] Address load puts slice or immediate on bus, captures address.
// [RULE17] Register load routes memory read data into slice data inputs.
// [RULE18] Register store puts slice data on bus, writes memory at held address.
// [RULE19] Status access selects status register as bus source or destination.
// [RULE20] Jump-and-save: immediate loads counter, old counter goes to slice; here counter plus four goes to slice.
// [RULE21] Cycle is 55 ns with 35 ns memory, stretched for slower memory; here 14 clocks of 4 ns, 56 ns.
// [RULE22] Taken branch lands one instruction late; next instruction runs first.
// [RULE23] Instruction port uses only upper 14 counter bits.
// [RULE24] Low two address bits enable one of four memory word pairs.
// [RULE25] Counter steps by four unless loaded; low two bits stay zero.
`timescale 1ns/1ps
`default_nettype none

module lwic_ctrl
    import lwic_pkg::*;
#(
    parameter int MEM_ACCESS_NS = 35,
    parameter logic [5:0] STATUS_SEL = 6'h3F,
    parameter int DADDR_W = 13
)
(
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic [13:0] IADDR,
    input wire logic [LWIC_IW-1:0] IDATA,
    output logic [DADDR_W-1:0] MEM_ADDR,
    output logic [3:0] MEM_PAIR_EN,
    output logic MEMORY_WRITE_STROBE,
    input wire logic [LWIC_DW-1:0] MEM_RDATA,
    output logic [LWIC_DW-1:0] DATA_BUS,
    output logic [5:0] IO_RD_SEL,
    output logic IO_RD_EN,
    input wire logic [LWIC_DW-1:0] IO_RDATA,
    output logic [5:0] IO_WR_SEL,
    output logic IO_WR_STROBE,
    output logic STAT_RD,
    output logic STAT_WR,
    output lwic_slice_t SLICE_CTRL,
    input wire logic [LWIC_DW-1:0] SLC_Y,
    input wire logic [63:0] COND_IN,
    output logic [LWIC_MISC_W-1:0] MISC_STROBE
);

    // Cycle length in system clocks, rounded up
    localparam int CYCLE_CLKS = (LWIC_CYCLE_NS * MEM_ACCESS_NS
        + LWIC_MEM_NOM_NS * LWIC_CLK_NS - 1) / (LWIC_MEM_NOM_NS * LWIC_CLK_NS); // [RULE21]
    localparam logic [7:0] TICK_LAST = 8'(CYCLE_CLKS - 1);

    lwic_state_t s_q;
    lwic_state_t s_d;

    logic [5:0] f_a;
    logic [5:0] f_b;
    logic [1:0] f_din;
    logic f_brd;
    logic f_bwr;
    logic f_mw;
    logic f_mar;
    logic f_jmp;
    logic f_jcnd;
    logic [15:0] f_imm;
    logic [15:0] bus_w;
    logic [15:0] ret_pc;
    logic pc_load;
    logic wb_req;
    logic wr_ok;

    // Field split
    assign f_a = s_q.ir[LWIC_A_LSB +: LWIC_SEL_W];
    assign f_b = s_q.ir[LWIC_B_LSB +: LWIC_SEL_W];
    assign f_din = s_q.ir[LWIC_DIN_LSB +: 2];
    assign f_brd = s_q.ir[LWIC_BRD_BIT];
    assign f_bwr = s_q.ir[LWIC_BWR_BIT];
    assign f_mw = s_q.ir[LWIC_MW_BIT];
    assign f_mar = s_q.ir[LWIC_MAR_BIT];
    assign f_jmp = s_q.ir[LWIC_JMP_BIT];
    assign f_jcnd = s_q.ir[LWIC_JCND_BIT];
    assign f_imm = s_q.ir[LWIC_IMM_LSB +: LWIC_DW];
    assign ret_pc = s_q.pc + LWIC_PC_STEP;

    // Bus source: I/O read, immediate, or slice output
    always_comb
    begin
        if (f_brd)
        begin
            bus_w = IO_RDATA; // [RULE10]
        end
        else if (f_din == LWIC_DIN_IMM || f_din == LWIC_DIN_PC)
        begin
            bus_w = f_imm; // [RULE16] [RULE20]
        end
        else
        begin
            bus_w = SLC_Y; // [RULE8] [RULE18]
        end
    end

    // Jump decision
    assign pc_load = f_jmp && (!f_jcnd || COND_IN[f_a]); // [RULE12] [RULE13]

    // Slice control
    always_comb
    begin
        SLICE_CTRL.a_addr = f_a; // [RULE3]
        SLICE_CTRL.b_addr = f_b; // [RULE3]
        SLICE_CTRL.func = s_q.ir[LWIC_FN_LSB +: LWIC_FN_W]; // [RULE4]
        SLICE_CTRL.carry_input_bit = s_q.ir[LWIC_CARRY_BIT]; // [RULE4]
        SLICE_CTRL.stat_en = s_q.ir[LWIC_STAT_BIT]; // [RULE4]
        SLICE_CTRL.shift = s_q.ir[LWIC_SHF_LSB +: 2]; // [RULE5]
        SLICE_CTRL.out_en = !f_brd; // [RULE10]
        case (f_din) // [RULE6]
            LWIC_DIN_BUS: SLICE_CTRL.din = bus_w;
            LWIC_DIN_IMM: SLICE_CTRL.din = f_imm;
            LWIC_DIN_PC: SLICE_CTRL.din = ret_pc; // [RULE20]
            LWIC_DIN_MEM: SLICE_CTRL.din = MEM_RDATA; // [RULE17]
            default: SLICE_CTRL.din = bus_w;
        endcase
    end

    // Data bus and I/O gating
    assign DATA_BUS = bus_w;
    assign IO_RD_SEL = f_a; // [RULE7]
    assign IO_WR_SEL = f_b; // [RULE7]
    assign IO_RD_EN = f_brd; // [RULE10]
    assign IO_WR_STROBE = f_bwr && s_q.step; // [RULE11]
    assign STAT_RD = f_brd && (f_a == STATUS_SEL); // [RULE19]
    assign STAT_WR = f_bwr && (f_b == STATUS_SEL) && s_q.step; // [RULE19]
    assign MEMORY_WRITE_STROBE = f_mw && s_q.step; // [RULE9] [RULE18]
    assign MISC_STROBE = s_q.ir[LWIC_MISC_LSB +: LWIC_MISC_W]; // [RULE1] [RULE14]

    // Memory addressing
    assign MEM_ADDR = s_q.memory_address_latch[DADDR_W-1:0]; // [RULE2]
    always_comb
    begin
        MEM_PAIR_EN = 4'h0;
        MEM_PAIR_EN[s_q.memory_address_latch[1:0]] = 1'b1; // [RULE24]
    end
    assign IADDR = s_q.pc[15:2]; // [RULE23]

    // Register bus outputs
    assign WB_DAT_O = s_q.rdata;
    assign WB_ACK_O = s_q.ack;
    assign wb_req = WB_CYC_I && WB_STB_I && !s_q.ack;
    assign wr_ok = wb_req && WB_WE_I && (WB_SEL_I[1:0] == 2'h3);

    // Next state
    always_comb
    begin
        s_d = s_q;
        s_d.ack = wb_req;
        s_d.step = 1'b0;
        if (s_q.run)
        begin
            if (s_q.tick == TICK_LAST)
            begin
                s_d.tick = 8'h00;
            end
            else
            begin
                s_d.tick = s_q.tick + 8'h01;
            end
            s_d.step = (s_q.tick == TICK_LAST - 8'h01); // [RULE21]
        end
        else
        begin
            s_d.tick = 8'h00;
        end
        if (s_q.step)
        begin
            s_d.ir = IDATA; // [RULE1]
            s_d.bus_seen = bus_w;
            if (pc_load)
            begin
                s_d.pc = {bus_w[15:2], 2'b00}; // [RULE12] [RULE22] [RULE25]
            end
            else
            begin
                s_d.pc = s_q.pc + LWIC_PC_STEP; // [RULE25]
            end
            if (f_mar)
            begin
                s_d.memory_address_latch = bus_w; // [RULE9] [RULE15] [RULE16]
            end
        end
        if (wr_ok)
        begin
            case (WB_ADR_I)
                LWIC_REG_CTRL:
                begin
                    s_d.run = WB_DAT_I[LWIC_CTRL_RUN];
                end
                LWIC_REG_PC:
                begin
                    if (!s_q.run)
                    begin
                        s_d.pc = {WB_DAT_I[15:2], 2'b00}; // [RULE25]
                    end
                end
                default:
                begin
                    s_d.run = s_q.run;
                end
            endcase
        end
        if (!s_q.run && !(wr_ok && WB_ADR_I == LWIC_REG_CTRL))
        begin
            s_d.ir = '0;
        end
        s_d.rdata = 32'h0000_0000;
        if (wb_req && !WB_WE_I)
        begin
            case (WB_ADR_I)
                LWIC_REG_CTRL: s_d.rdata = {31'h0000_0000, s_q.run};
                LWIC_REG_PC: s_d.rdata = {16'h0000, s_q.pc};
                LWIC_REG_MAR: s_d.rdata = {16'h0000, s_q.memory_address_latch};
                LWIC_REG_BUS: s_d.rdata = {16'h0000, s_q.bus_seen};
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            s_q.pc <= LWIC_PC_RST;
            s_q.ir <= '0;
            s_q.memory_address_latch <= LWIC_MAR_RST;
            s_q.bus_seen <= 16'h0000;
            s_q.tick <= 8'h00;
            s_q.step <= 1'b0;
            s_q.run <= 1'b0;
            s_q.ack <= 1'b0;
            s_q.rdata <= 32'h0000_0000;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Checks
    pc_step_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE25]
        (s_q.step && !pc_load) |=> (s_q.pc == $past(s_q.pc) + LWIC_PC_STEP))
        else $error("counter did not step by four");

    pc_branch_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE12]
        (s_q.step && pc_load) |=> (s_q.pc == {$past(bus_w[15:2]), 2'b00}))
        else $error("branch did not load counter from bus");

    pc_align_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE25]
        s_q.pc[1:0] == 2'b00)
        else $error("counter low bits not zero");

    cond_gate_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE13]
        (f_jmp && f_jcnd && !COND_IN[f_a] && s_q.step) |=> (s_q.pc == $past(ret_pc)))
        else $error("false condition still branched");

    bus_default_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE8]
        (!f_brd && f_din != LWIC_DIN_IMM && f_din != LWIC_DIN_PC)
        |-> (DATA_BUS == SLC_Y && SLICE_CTRL.out_en))
        else $error("slice output not on bus");

    bus_read_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE10]
        f_brd |-> (DATA_BUS == IO_RDATA && !SLICE_CTRL.out_en && IO_RD_SEL == f_a))
        else $error("bus read not steered");

    mar_load_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE9]
        (s_q.step && f_mar) |=> (s_q.memory_address_latch == $past(bus_w)))
        else $error("address latch missed bus");

    mem_write_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE9]
        MEMORY_WRITE_STROBE |-> (s_q.step && f_mw) ##1 !MEMORY_WRITE_STROBE)
        else $error("memory write outside step");

    step_space_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE21]
        s_q.step |-> (s_q.tick == TICK_LAST) ##1 !s_q.step [*8])
        else $error("cycle shorter than expected");

    jsr_path_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE20]
        (f_din == LWIC_DIN_PC && !f_brd) |-> (SLICE_CTRL.din == ret_pc && DATA_BUS == f_imm))
        else $error("save-return paths wrong");

    pair_en_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE24]
        MEM_PAIR_EN == (4'h1 << s_q.memory_address_latch[1:0]))
        else $error("wrong memory pair enabled");

    fetch_a: assert property (@(posedge CLK_SYS) disable iff (RST) // [RULE1]
        (s_q.step && s_q.run) |=> (s_q.ir == $past(IDATA)))
        else $error("instruction not fetched");

endmodule : lwic_ctrl

`default_nettype wire

/* File: logic/lwic_pkg.sv */
// Constants and types for the long-word instruction control block.
// Assumes a single system clock; used by the control module, the store model and the bench.
package lwic_pkg;

    // Instruction word layout
    localparam int LWIC_IW = 64;
    localparam int LWIC_A_LSB = 58;
    localparam int LWIC_B_LSB = 52;
    localparam int LWIC_FN_LSB = 42;
    localparam int LWIC_CARRY_BIT = 41;
    localparam int LWIC_STAT_BIT = 40;
    localparam int LWIC_DIN_LSB = 38;
    localparam int LWIC_BRD_BIT = 37;
    localparam int LWIC_BWR_BIT = 36;
    localparam int LWIC_MW_BIT = 35;
    localparam int LWIC_MAR_BIT = 34;
    localparam int LWIC_JMP_BIT = 33;
    localparam int LWIC_JCND_BIT = 32;
    localparam int LWIC_SHF_LSB = 30;
    localparam int LWIC_MISC_LSB = 16;
    localparam int LWIC_IMM_LSB = 0;
    localparam int LWIC_SEL_W = 6;
    localparam int LWIC_FN_W = 10;
    localparam int LWIC_MISC_W = 14;
    localparam int LWIC_DW = 16;

    // Data-input source codes
    localparam logic [1:0] LWIC_DIN_BUS = 2'h0;
    localparam logic [1:0] LWIC_DIN_IMM = 2'h1;
    localparam logic [1:0] LWIC_DIN_PC = 2'h2;
    localparam logic [1:0] LWIC_DIN_MEM = 2'h3;

    // Program counter stepping
    localparam logic [15:0] LWIC_PC_STEP = 16'h0004;
    localparam logic [15:0] LWIC_PC_RST = 16'h0000;
    localparam logic [15:0] LWIC_MAR_RST = 16'h0000;

    // Register map (byte addresses)
    localparam logic [7:0] LWIC_REG_CTRL = 8'h00;
    localparam logic [7:0] LWIC_REG_PC = 8'h04;
    localparam logic [7:0] LWIC_REG_MAR = 8'h08;
    localparam logic [7:0] LWIC_REG_BUS = 8'h0C;
    localparam int LWIC_CTRL_RUN = 0;

    // Cycle timing
    localparam int LWIC_CYCLE_NS = 55;
    localparam int LWIC_MEM_NOM_NS = 35;
    localparam int LWIC_CLK_NS = 4;

    typedef struct packed {
        logic [LWIC_SEL_W-1:0] a_addr;
        logic [LWIC_SEL_W-1:0] b_addr;
        logic [LWIC_FN_W-1:0] func;
        logic carry_input_bit;
        logic stat_en;
        logic [1:0] shift;
        logic out_en;
        logic [LWIC_DW-1:0] din;
    } lwic_slice_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [LWIC_IW-1:0] ir;
        logic [15:0] memory_address_latch;
        logic [15:0] bus_seen;
        logic [7:0] tick;
        logic step;
        logic run;
        logic ack;
        logic [31:0] rdata;
    } lwic_state_t;

endpackage : lwic_pkg

/* File: tb/lwic_store_model.sv */
// Behavioural dual-port control store, I/O registers and slice output.
// Assumes the control block drives its ports on CLK_SYS.
`timescale 1ns/1ps
`default_nettype none
module lwic_store_model
    import lwic_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic [13:0] IADDR,
    output logic [LWIC_IW-1:0] IDATA,
    input wire logic [12:0] MEM_ADDR,
    input wire logic MEMORY_WRITE_STROBE,
    output logic [LWIC_DW-1:0] MEM_RDATA,
    input wire logic [LWIC_DW-1:0] DATA_BUS,
    input wire logic [5:0] IO_RD_SEL,
    output logic [LWIC_DW-1:0] IO_RDATA,
    input wire logic [5:0] IO_WR_SEL,
    input wire logic IO_WR_STROBE,
    input wire lwic_slice_t SLICE_CTRL,
    output logic [LWIC_DW-1:0] SLC_Y
);
    logic [15:0] dmem [0:8191];
    logic [12:0] ib;
    logic [15:0] io_data_q;
    logic [5:0] io_sel_q;
    initial
    begin
        for (int i = 0; i < 8192; i++)
            dmem[i] = 16'h0000;
    end
    assign ib = {IADDR[10:0], 2'h0};
    assign IDATA = {dmem[ib], dmem[ib + 13'h1], dmem[ib + 13'h2], dmem[ib + 13'h3]};
    assign MEM_RDATA = dmem[MEM_ADDR];
    assign IO_RDATA = {10'h155, IO_RD_SEL};
    // Disabled slice output shows a pattern, not the last value
    assign SLC_Y = SLICE_CTRL.out_en ? {SLICE_CTRL.a_addr, SLICE_CTRL.func}
                                     : ~{SLICE_CTRL.a_addr, SLICE_CTRL.func};
    always @(posedge CLK_SYS)
    begin
        if (MEMORY_WRITE_STROBE)
            dmem[MEM_ADDR] <= DATA_BUS;
        if (IO_WR_STROBE)
        begin
            io_data_q <= DATA_BUS;
            io_sel_q <= IO_WR_SEL;
        end
    end
    task automatic put(input logic [12:0] a, input logic [63:0] w);
        {dmem[a], dmem[a + 13'h1], dmem[a + 13'h2], dmem[a + 13'h3]} = w;
    endtask : put
endmodule : lwic_store_model
`default_nettype wire

/* File: tb/tb_long_word_instruction_control.sv */
// Self-checking bench for the long-word instruction control block.
// Assumes the store model on the far side and a Wishbone master here.
`timescale 1ns/1ps
`default_nettype none
module tb_long_word_instruction_control;
    import lwic_pkg::*;
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic WB_CYC_I = 1'b0;
    logic WB_STB_I = 1'b0;
    logic WB_WE_I = 1'b0;
    logic [7:0] WB_ADR_I = 8'h00;
    logic [3:0] WB_SEL_I = 4'h0;
    logic [31:0] WB_DAT_I = 32'h0000_0000;
    logic [31:0] WB_DAT_O;
    logic WB_ACK_O, MEMORY_WRITE_STROBE, IO_RD_EN, IO_WR_STROBE, STAT_RD, STAT_WR;
    logic [13:0] IADDR, MISC_STROBE;
    logic [63:0] IDATA;
    logic [63:0] COND_IN = 64'h0000_0000_0000_0400;
    logic [12:0] MEM_ADDR;
    logic [3:0] MEM_PAIR_EN;
    logic [15:0] MEM_RDATA, DATA_BUS, IO_RDATA, SLC_Y;
    logic [5:0] IO_RD_SEL, IO_WR_SEL;
    lwic_slice_t SLICE_CTRL;
    int num_errors = 0;
    int check_count = 0;
    realtime t0;
    logic [31:0] q;
    lwic_ctrl i_dut (.CLK_SYS(CLK_SYS), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
        .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
        .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .IADDR(IADDR), .IDATA(IDATA),
        .MEM_ADDR(MEM_ADDR), .MEM_PAIR_EN(MEM_PAIR_EN), .MEM_RDATA(MEM_RDATA),
        .MEMORY_WRITE_STROBE(MEMORY_WRITE_STROBE), .DATA_BUS(DATA_BUS),
        .IO_RD_SEL(IO_RD_SEL), .IO_RD_EN(IO_RD_EN), .IO_RDATA(IO_RDATA),
        .IO_WR_SEL(IO_WR_SEL), .IO_WR_STROBE(IO_WR_STROBE), .STAT_RD(STAT_RD),
        .STAT_WR(STAT_WR), .SLICE_CTRL(SLICE_CTRL), .SLC_Y(SLC_Y), .COND_IN(COND_IN),
        .MISC_STROBE(MISC_STROBE));
    lwic_store_model i_mem (.CLK_SYS(CLK_SYS), .IADDR(IADDR), .IDATA(IDATA),
        .MEM_ADDR(MEM_ADDR), .MEMORY_WRITE_STROBE(MEMORY_WRITE_STROBE),
        .MEM_RDATA(MEM_RDATA), .DATA_BUS(DATA_BUS), .IO_RD_SEL(IO_RD_SEL),
        .IO_RDATA(IO_RDATA), .IO_WR_SEL(IO_WR_SEL), .IO_WR_STROBE(IO_WR_STROBE),
        .SLICE_CTRL(SLICE_CTRL), .SLC_Y(SLC_Y));
    initial
    begin
        forever #2 CLK_SYS = ~CLK_SYS;
    end
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        int i;
        @(posedge CLK_SYS);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I <= we;
        WB_ADR_I <= a;
        WB_SEL_I <= s;
        WB_DAT_I <= d;
        for (i = 0; i < 20; i++)
        begin
            @(posedge CLK_SYS);
            if (WB_ACK_O === 1'b1)
                break;
        end
        q = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        chk("ack wait", i < 20, 1'b1);
        if (i == 20)
            print_verdict();
    endtask : wb
    // Next instruction must show within about one step
    task automatic exec(input logic [13:0] m);
        int i;
        for (i = 0; i < 20; i++)
        begin
            @(posedge CLK_SYS);
            #1;
            if (MISC_STROBE === m)
                break;
        end
        chk("misc", MISC_STROBE, m);
        if (i == 20)
            print_verdict();
    endtask : exec
    function automatic logic [63:0] iw(input logic [5:0] a, input logic [5:0] b,
        input logic [1:0] din, input logic [5:0] ctl, input logic [13:0] m,
        input logic [15:0] imm);
        return {a, b, 10'h0AB, 2'b11, din, ctl, 2'b10, m, imm};
    endfunction : iw
    task automatic t_regs;
        wb(1'b0, 8'h00, 4'hF, 32'h0);
        chk("ctrl", q, 32'h0000_0000);
        wb(1'b0, 8'h08, 4'hF, 32'h0);
        chk("latch", q, 32'h0000_0000);
        wb(1'b0, 8'h10, 4'hF, 32'h0);
        chk("unmapped", q, 32'h0000_0000);
        wb(1'b1, 8'h04, 4'hF, 32'h0000_0007);
        wb(1'b0, 8'h04, 4'hF, 32'h0);
        chk("pc", q, 32'h0000_0004);
        wb(1'b1, 8'h04, 4'hF, 32'h0000_0000);
        wb(1'b1, 8'h00, 4'hC, 32'h0000_0001);
        wb(1'b0, 8'h00, 4'hF, 32'h0);
        chk("ctrl sel", q, 32'h0000_0000);
    endtask : t_regs
    task automatic t_prog;
        wb(1'b1, 8'h00, 4'hF, 32'h0000_0001);
        exec(14'h1);
        chk("bus imm", DATA_BUS, 16'h0123);
        exec(14'h2);
        chk("bus slice", DATA_BUS, 16'h44AB);
        chk("slice", SLICE_CTRL[42:16], {6'h11, 6'h02, 10'h0AB, 4'b1110, 1'b1});
        exec(14'h3);
        chk("load", SLICE_CTRL.din, 16'h44AB);
        chk("addr", MEM_ADDR, 13'h0123);
        chk("pair", MEM_PAIR_EN, 4'b1000);
        exec(14'h4);
        chk("jump bus", DATA_BUS, 16'h0040);
        exec(14'h5);
        chk("io rd", {IO_RD_EN, SLICE_CTRL.out_en, IO_RD_SEL}, {2'b10, 6'h05});
        chk("io bus", DATA_BUS, 16'h5545);
        exec(14'h6);
        chk("io wr", {i_mem.io_sel_q, i_mem.io_data_q}, {6'h07, 16'h5545});
        chk("jsr", {SLICE_CTRL.b_addr, DATA_BUS, SLICE_CTRL.din}, {6'h3, 32'h0080_0048});
        exec(14'h7);
        t0 = $realtime;
        exec(14'h8);
        chk("cycle ns", int'($realtime - t0), 14 * LWIC_CLK_NS);
        exec(14'h9);
        exec(14'hA);
        exec(14'hB);
        chk("stat rd", STAT_RD, 1'b1);
        for (int k = 0; k < 20 && STAT_WR !== 1'b1; k++)
            @(posedge CLK_SYS);
        chk("stat wr", {STAT_WR, IO_WR_SEL}, {1'b1, 6'h3F});
        wb(1'b1, 8'h00, 4'hF, 32'h0000_0000);
        @(posedge CLK_SYS);
        #1;
        chk("stopped", MISC_STROBE, 14'h0);
        wb(1'b0, 8'h08, 4'hF, 32'h0);
        chk("latch", q, 32'h0000_0123);
    endtask : t_prog
    initial
    begin
        repeat (8) @(posedge CLK_SYS);
        i_mem.put(13'h0000, iw(6'h00, 6'h00, 2'h1, 6'b000100, 14'h1, 16'h0123));
        i_mem.put(13'h0004, iw(6'h11, 6'h02, 2'h0, 6'b001000, 14'h2, 16'h0000));
        i_mem.put(13'h0008, iw(6'h00, 6'h00, 2'h3, 6'b000000, 14'h3, 16'h0000));
        i_mem.put(13'h000C, iw(6'h00, 6'h00, 2'h1, 6'b000010, 14'h4, 16'h0040));
        i_mem.put(13'h0010, iw(6'h05, 6'h07, 2'h0, 6'b110000, 14'h5, 16'h0000));
        i_mem.put(13'h0040, iw(6'h00, 6'h03, 2'h2, 6'b000010, 14'h6, 16'h0080));
        i_mem.put(13'h0044, iw(6'h00, 6'h00, 2'h0, 6'b000000, 14'h7, 16'h0000));
        i_mem.put(13'h0080, iw(6'h09, 6'h00, 2'h1, 6'b000011, 14'h8, 16'h0200));
        i_mem.put(13'h0084, iw(6'h0A, 6'h00, 2'h1, 6'b000011, 14'h9, 16'h0100));
        i_mem.put(13'h0088, iw(6'h00, 6'h00, 2'h0, 6'b000000, 14'hA, 16'h0000));
        i_mem.put(13'h0100, iw(6'h3F, 6'h3F, 2'h0, 6'b110000, 14'hB, 16'h0000));
        repeat (8) @(posedge CLK_SYS);
        RST <= 1'b0;
        t_regs();
        t_prog();
        print_verdict();
    end
endmodule : tb_long_word_instruction_control
`default_nettype wire
